// ==== core/acsc_defines.svh ====
/*
  Register offsets, field positions, reset values and counts of the
  converter sequencing control block.
  Assumes a 32-bit AHB-Lite slave with word-indexed registers.
*/
`ifndef ACSC_DEFINES_SVH
`define ACSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACSC_IDX_CTRL1 4'h0
`define ACSC_IDX_CMD 4'h2
`define ACSC_IDX_STAT 4'h3

// ----------------------------------------------------------------
// converter_control_one fields
// ----------------------------------------------------------------
`define ACSC_RESET_BIT 14
`define ACSC_SUSPEND_BEHAVIOUR_SELECT_LSB 12
`define ACSC_ACQ_LSB 8
`define ACSC_CPS_BIT 7
`define ACSC_CONT_BIT 6
`define ACSC_WRAP_BIT 5
`define ACSC_CTRL1_RST 16'h0000

// ----------------------------------------------------------------
// Sequencer command and status fields
// ----------------------------------------------------------------
`define ACSC_START_BIT 0
`define ACSC_SEQRST_BIT 1
`define ACSC_MAXCONV_LSB 4
`define ACSC_MAXCONV_RST 4'h0
`define ACSC_PTR_LSB 0
`define ACSC_STATE_LSB 4
`define ACSC_HALT_BIT 8
`define ACSC_CONTEFF_BIT 9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACSC_CONV_CLKS 16

`endif

// ==== core/acsc_pkg.sv ====
/*
  Types of the converter sequencing control block: modes, sequencer
  states and the packed state record of the control module.
  Assumes the constants header is compiled alongside.
*/
package acsc_pkg;

  // Suspend behaviour, in field encoding order
  typedef enum logic [1:0] {ACSC_SUS_IGNORE, ACSC_SUS_AFTER_SEQ, ACSC_SUS_AFTER_CONV, ACSC_SUS_AT_ONCE} acsc_susmode_t;

  // Sequencer phases of one conversion
  typedef enum logic [1:0] {ACSC_IDLE, ACSC_SAMPLE, ACSC_CONVERT, ACSC_LATCH} acsc_seq_t;

  // Software controlled fields of converter_control_one
  typedef struct packed {
    acsc_susmode_t suspend_behaviour_select;
    logic [3:0] acq;
    logic core_clock_halver;
    logic cont;
    logic wrap;
  } acsc_ctrl_t;

  // Whole state of the control module
  typedef struct packed {
    acsc_ctrl_t ctrl;
    logic soft_rst;
    logic [3:0] max_conv;
    logic cont_eff;
    acsc_seq_t seq;
    logic [3:0] ptr;
    logic [7:0] cnt;
    logic start_pend;
    logic div;
    logic tick;
    logic halted;
    logic soc;
    logic end_of_sequence;
    logic rstb;
    logic [3:0] ridx;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic susp_s1;
    logic susp_s2;
    logic bus_act;
    logic bus_wr;
    logic [3:0] bus_idx;
    logic [31:0] rdata;
    logic hready;
    logic hresp;
  } acsc_state_t;

endpackage

// ==== core/acsc_ctrl_one.sv ====
/*
  Converter sequencing control: control register one, soft reset,
  suspend handling, sampling window, converter clock halver and the
  conversion sequencer, behind an AHB-Lite slave.
  Assumes CORE_CLK is the prescaled fast peripheral clock and that
  EMU_SUSPEND and START_TRIG arrive asynchronously from pins.
*/
// Overview of operation
// - Writing one to module reset bit resets all but bus phase and pin stages, bit then self-clears.
// - System reset resets the whole block without software help.
// - Suspend mode 00 ignores emulation suspend entirely.
// - Suspend mode 01 halts after current sequence ends and result latches.
// - Suspend mode 10 halts after current conversion ends and result latches.
// - Suspend mode 11 halts sequencer immediately on suspend.
// - Start-of-conversion pulse lasts acquisition field plus one converter clocks.
// - Converter clock is core clock undivided, or halved when halver bit set.
// - Continuous-run writes accepted anytime, applied only at end of sequence.
// - Module reset bit always reads zero.
// - Module reset returns all registers and sequencer to initial state.
// - Start-stop mode stops at end of sequence, resumes from there next trigger.
// - Continuous mode restarts from zero, or continues when wrap override set.
`timescale 1ns/1ps
`default_nettype none
`include "acsc_defines.svh"

module acsc_ctrl_one
  import acsc_pkg::*;
#(
  parameter int CONV_CLKS = `ACSC_CONV_CLKS
) (
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Pins
  input wire logic EMU_SUSPEND,
  input wire logic START_TRIG,
  // Converter side
  output logic SOC_PULSE,
  output logic CONV_CLK_EN,
  output logic END_OF_SEQ,
  output logic RESULT_STROBE,
  output logic [3:0] RESULT_INDEX,
  output logic SEQ_HALTED
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CONV_CLKS < 1 || CONV_CLKS > 256) begin : g_bad_conv
    $error("CONV_CLKS must lie between 1 and 256");
  end

  localparam logic [7:0] CONV_LAST = 8'(CONV_CLKS - 1);

  // Reset image of the whole state
  function automatic acsc_state_t rst_state();
    acsc_state_t st;
    st = '0;
    st.ctrl.suspend_behaviour_select = ACSC_SUS_IGNORE;
    st.ctrl.acq = 4'(`ACSC_CTRL1_RST >> `ACSC_ACQ_LSB);
    st.max_conv = `ACSC_MAXCONV_RST;
    st.seq = ACSC_IDLE;
    st.hready = 1'b1;
    return st;
  endfunction

  acsc_state_t s_q;
  acsc_state_t s_d;
  logic adv;
  logic hold;
  logic eos_now;
  logic wr_now;
  logic addr_ok;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Sequencer steps on converter clock ticks it is not held on; sequence reset and soft reset act on any cycle
  always_comb begin
    s_d = s_q;
    s_d.end_of_sequence = 1'b0;
    s_d.rstb = 1'b0;
    // Pin synchronisers, the third stage feeds the edge detector
    s_d.susp_s1 = EMU_SUSPEND;
    s_d.susp_s2 = s_q.susp_s1;
    s_d.trig_s1 = START_TRIG;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    // Converter clock halver
    s_d.div = ~s_q.div;
    s_d.tick = ~s_q.ctrl.core_clock_halver | s_q.div;
    hold = s_q.halted || (s_q.ctrl.suspend_behaviour_select == ACSC_SUS_AT_ONCE && s_q.susp_s2);
    adv = s_q.tick && !hold;
    eos_now = (s_q.ptr == s_q.max_conv);
    wr_now = s_q.bus_act && s_q.bus_wr;
    // Sequencer
    case (s_q.seq)
      ACSC_IDLE: begin
        s_d.cont_eff = s_q.ctrl.cont;
        if (adv && s_q.start_pend) begin
          s_d.start_pend = 1'b0;
          s_d.seq = ACSC_SAMPLE;
          s_d.cnt = 8'h00;
          s_d.soc = 1'b1;
        end
      end
      ACSC_SAMPLE: begin
        if (adv) begin
          if (s_q.cnt == {4'h0, s_q.ctrl.acq}) begin
            s_d.seq = ACSC_CONVERT;
            s_d.cnt = 8'h00;
            s_d.soc = 1'b0;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      ACSC_CONVERT: begin
        if (adv) begin
          if (s_q.cnt == CONV_LAST) begin
            s_d.seq = ACSC_LATCH;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      end
      ACSC_LATCH: begin
        if (adv) begin
          s_d.rstb = 1'b1;
          s_d.ridx = s_q.ptr;
          s_d.cnt = 8'h00;
          s_d.seq = ACSC_SAMPLE;
          s_d.soc = 1'b1;
          s_d.ptr = s_q.ptr + 4'h1;
          if (eos_now) begin
            s_d.end_of_sequence = 1'b1;
            s_d.cont_eff = s_q.ctrl.cont;
            if (!s_q.ctrl.cont) begin
              s_d.seq = ACSC_IDLE;
              s_d.soc = 1'b0;
            end else if (!s_q.ctrl.wrap) begin
              s_d.ptr = 4'h0;
            end
          end
        end
      end
      default: begin
        s_d.seq = ACSC_IDLE;
      end
    endcase
    // Suspend: halted stays until the request goes away
    case (s_q.ctrl.suspend_behaviour_select)
      ACSC_SUS_AFTER_SEQ: begin
        s_d.halted = s_q.susp_s2 && (s_q.halted || s_q.seq == ACSC_IDLE ||
                     (adv && s_q.seq == ACSC_LATCH && eos_now));
      end
      ACSC_SUS_AFTER_CONV: begin
        s_d.halted = s_q.susp_s2 && (s_q.halted || s_q.seq == ACSC_IDLE ||
                     (adv && s_q.seq == ACSC_LATCH));
      end
      ACSC_SUS_AT_ONCE: begin
        s_d.halted = s_q.susp_s2;
      end
      default: begin
        s_d.halted = 1'b0;
      end
    endcase
    // Register writes in the data phase; register effects beat sequencing
    if (wr_now) begin
      case (s_q.bus_idx)
        `ACSC_IDX_CTRL1: begin
          s_d.soft_rst = HWDATA[`ACSC_RESET_BIT];
          s_d.ctrl.suspend_behaviour_select = acsc_susmode_t'(HWDATA[`ACSC_SUSPEND_BEHAVIOUR_SELECT_LSB +: 2]);
          s_d.ctrl.acq = HWDATA[`ACSC_ACQ_LSB +: 4];
          s_d.ctrl.core_clock_halver = HWDATA[`ACSC_CPS_BIT];
          s_d.ctrl.cont = HWDATA[`ACSC_CONT_BIT];
          s_d.ctrl.wrap = HWDATA[`ACSC_WRAP_BIT];
        end
        `ACSC_IDX_CMD: begin
          s_d.max_conv = HWDATA[`ACSC_MAXCONV_LSB +: 4];
          if (HWDATA[`ACSC_SEQRST_BIT]) begin
            s_d.seq = ACSC_IDLE;
            s_d.ptr = 4'h0;
            s_d.cnt = 8'h00;
            s_d.soc = 1'b0;
            s_d.start_pend = 1'b0;
          end
          if (HWDATA[`ACSC_START_BIT]) begin
            s_d.start_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Start requests wait for a tick; a pin edge is applied after the
    // sequencer and the command write so that set wins over consumption
    if (s_q.trig_s2 && !s_q.trig_s3) begin
      s_d.start_pend = 1'b1;
    end
    // Soft reset: everything but bus phase and pin stages
    if (s_q.soft_rst) begin
      s_d = rst_state();
      s_d.susp_s1 = EMU_SUSPEND;
      s_d.susp_s2 = s_q.susp_s1;
      s_d.trig_s1 = START_TRIG;
      s_d.trig_s2 = s_q.trig_s1;
      s_d.trig_s3 = s_q.trig_s2;
    end
    // Address phase; read data comes from the next state so a read
    // right after a write already sees it
    addr_ok = HADDR[31:6] == 26'h0 && HADDR[1:0] == 2'b00;
    s_d.bus_act = HSEL && HTRANS[1] && HREADY && addr_ok;
    s_d.bus_wr = HWRITE;
    s_d.bus_idx = HADDR[5:2];
    s_d.hready = 1'b1;
    s_d.hresp = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (s_d.bus_act && !HWRITE) begin
      case (HADDR[5:2])
        `ACSC_IDX_CTRL1: begin
          s_d.rdata[`ACSC_SUSPEND_BEHAVIOUR_SELECT_LSB +: 2] = s_d.ctrl.suspend_behaviour_select;   // reset bit reads 0
          s_d.rdata[`ACSC_ACQ_LSB +: 4] = s_d.ctrl.acq;
          s_d.rdata[`ACSC_CPS_BIT] = s_d.ctrl.core_clock_halver;
          s_d.rdata[`ACSC_CONT_BIT] = s_d.ctrl.cont;
          s_d.rdata[`ACSC_WRAP_BIT] = s_d.ctrl.wrap;
        end
        `ACSC_IDX_CMD: begin
          s_d.rdata[`ACSC_MAXCONV_LSB +: 4] = s_d.max_conv;
        end
        `ACSC_IDX_STAT: begin
          s_d.rdata[`ACSC_PTR_LSB +: 4] = s_d.ptr;
          s_d.rdata[`ACSC_STATE_LSB +: 2] = s_d.seq;
          s_d.rdata[`ACSC_HALT_BIT] = s_d.halted;
          s_d.rdata[`ACSC_CONTEFF_BIT] = s_d.cont_eff;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // System reset reaches everything, enable low freezes everything
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_q <= rst_state();
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state record
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = s_q.hready;
  assign HRESP = s_q.hresp;
  assign SOC_PULSE = s_q.soc;
  assign CONV_CLK_EN = s_q.tick;
  assign END_OF_SEQ = s_q.end_of_sequence;
  assign RESULT_STROBE = s_q.rstb;
  assign RESULT_INDEX = s_q.ridx;
  assign SEQ_HALTED = s_q.halted;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_soft_rst_self_clear;
    CE && wr_now && s_q.bus_idx == `ACSC_IDX_CTRL1 && HWDATA[`ACSC_RESET_BIT] ##1 CE |=> !s_q.soft_rst;
  endproperty
  a_soft_rst_self_clear: assert property (p_soft_rst_self_clear) else $error("reset bit did not clear");

  property p_reset_reads_zero;
    s_q.bus_act && !s_q.bus_wr && s_q.bus_idx == `ACSC_IDX_CTRL1 |-> !HRDATA[`ACSC_RESET_BIT];
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero) else $error("reset bit read as one");

  property p_soft_rst_clears_all;
    CE && s_q.soft_rst |=> s_q.ctrl == '0 && s_q.seq == ACSC_IDLE && s_q.ptr == 4'h0 && !s_q.soc;
  endproperty
  a_soft_rst_clears_all: assert property (p_soft_rst_clears_all) else $error("soft reset left state");

  property p_mode0_no_halt;
    s_q.ctrl.suspend_behaviour_select == ACSC_SUS_IGNORE && $past(s_q.ctrl.suspend_behaviour_select) == ACSC_SUS_IGNORE |-> !s_q.halted;
  endproperty
  a_mode0_no_halt: assert property (p_mode0_no_halt) else $error("halted in ignore mode");

  property p_mode1_halt;
    CE && !s_q.soft_rst && !wr_now && s_q.ctrl.suspend_behaviour_select == ACSC_SUS_AFTER_SEQ && s_q.susp_s2 && adv &&
      s_q.seq == ACSC_LATCH && eos_now |=> s_q.halted && s_q.end_of_sequence;
  endproperty
  a_mode1_halt: assert property (p_mode1_halt) else $error("no halt after sequence");

  property p_mode2_halt;
    CE && !s_q.soft_rst && !wr_now && s_q.ctrl.suspend_behaviour_select == ACSC_SUS_AFTER_CONV && s_q.susp_s2 && adv &&
      s_q.seq == ACSC_LATCH |=> s_q.halted && s_q.rstb;
  endproperty
  a_mode2_halt: assert property (p_mode2_halt) else $error("no halt after conversion");

  property p_mode3_freeze;
    CE && !s_q.soft_rst && !wr_now && s_q.ctrl.suspend_behaviour_select == ACSC_SUS_AT_ONCE && s_q.susp_s2 |=>
      $stable(s_q.seq) && $stable(s_q.ptr) && $stable(s_q.cnt) && s_q.halted;
  endproperty
  a_mode3_freeze: assert property (p_mode3_freeze) else $error("sequencer moved in suspend");

  property p_soc_width;
    CE && !s_q.soft_rst && !wr_now && s_q.seq == ACSC_SAMPLE && adv |=>
      (s_q.seq == ACSC_CONVERT) == ($past(s_q.cnt) == {4'h0, $past(s_q.ctrl.acq)}) && (s_q.soc == (s_q.seq == ACSC_SAMPLE));
  endproperty
  a_soc_width: assert property (p_soc_width) else $error("sample window length wrong");

  property p_tick_rate;
    CE && !s_q.soft_rst && (!s_q.ctrl.core_clock_halver || $past(s_q.ctrl.core_clock_halver)) |=>
      s_q.tick == (!$past(s_q.ctrl.core_clock_halver) || !$past(s_q.tick));
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("converter tick wrong");

  property p_cont_held;
    CE && !s_q.soft_rst && s_q.seq != ACSC_IDLE && !(adv && s_q.seq == ACSC_LATCH && eos_now) |=> $stable(s_q.cont_eff);
  endproperty
  a_cont_held: assert property (p_cont_held) else $error("run mode changed mid sequence");

  property p_stop_at_end;
    CE && !s_q.soft_rst && !wr_now && adv && s_q.seq == ACSC_LATCH && eos_now && !s_q.ctrl.cont |=>
      s_q.seq == ACSC_IDLE && s_q.ptr == $past(s_q.ptr) + 4'h1;
  endproperty
  a_stop_at_end: assert property (p_stop_at_end) else $error("start-stop end wrong");

  property p_cont_wrap;
    CE && !s_q.soft_rst && !wr_now && adv && s_q.seq == ACSC_LATCH && eos_now && s_q.ctrl.cont && !s_q.ctrl.wrap |=>
      s_q.seq == ACSC_SAMPLE && s_q.ptr == 4'h0;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("continuous restart wrong");

endmodule
`default_nettype wire

// ==== testbench/tb_acsc_ctrl_one.sv ====
/*
  Self-checking bench for the converter sequencing control block: control
  register fields, soft reset, sampling window, clock halver, sequencing
  modes and the four suspend behaviours.
  Assumes the design files under core/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_acsc_ctrl_one;
  // Short conversions keep every sequence to a few dozen cycles
  localparam int CONV_N = 2;
  localparam logic [31:0] A_CTRL = 32'h0000_0000;
  localparam logic [31:0] A_CMD = 32'h0000_0008;
  localparam logic [31:0] A_STAT = 32'h0000_000C;

  // ------------------------------------------------------------
  // Stimulus, observed outputs and counters
  // ------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic emu_susp = 1'h0;
  logic start_pin = 1'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, soc, tick, end_of_sequence, rstb, halted;
  logic [3:0] ridx;
  logic [3:0] last_idx = 4'h0;
  logic [3:0] acq_tab [3] = '{4'h0, 4'h5, 4'hF};
  int n_res = 0, n_eos = 0, n_tick = 0, soc_run = 0, soc_w = 0, cyc_n = 0;
  int fail_count = 0, checked = 0;

  always #2 clk = ~clk;

  acsc_ctrl_one #(.CONV_CLKS(CONV_N)) dut_u (
    .CORE_CLK(clk), .RST_N(rst_n), .CE(1'h1),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .EMU_SUSPEND(emu_susp), .START_TRIG(start_pin),
    .SOC_PULSE(soc), .CONV_CLK_EN(tick), .END_OF_SEQ(end_of_sequence),
    .RESULT_STROBE(rstb), .RESULT_INDEX(ridx), .SEQ_HALTED(halted)
  );

  // Outputs are registers, so mid-cycle sampling never races the edge
  always @(negedge clk) begin
    if (rstb === 1'h1) begin
      n_res++;
      last_idx = ridx;
    end
    if (end_of_sequence === 1'h1) n_eos++;
    if (tick === 1'h1) n_tick++;
    if (soc === 1'h1) soc_run++;
    else if (soc_run != 0) begin
      soc_w = soc_run;
      soc_run = 0;
    end
  end

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // One single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask

  task automatic rdchk(string what, logic [31:0] a, logic [31:0] mask, logic [31:0] exp);
    logic [31:0] x;
    bus(1'h0, a, 32'h0000_0000, x);
    chk(what, exp, x & mask);
  endtask

  // Bounded wait for a count of end-of-sequence or result pulses
  task automatic wait_ev(logic on_eos, int target);
    int k;
    k = 0;
    while (((on_eos ? n_eos : n_res) < target) && k < 1000) begin
      @(posedge clk);
      k++;
    end
    chk("pulse wait", 32'h0000_0001, {31'h0, k < 1000});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk("reset outputs", 32'h0, {26'h0, soc, end_of_sequence, rstb, halted, hresp, ~hreadyout});
    rdchk("ctrl reset", A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("status reset", A_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(A_CTRL, 32'hFFFF_BFEF);
    rdchk("ctrl fields", A_CTRL, 32'hFFFF_FFFF, 32'h0000_3FE0);
    rdchk("unmapped", 32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_7FE0);
    cyc(4);
    rdchk("ctrl soft reset", A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_soc(logic [3:0] acq, logic core_clock_halver);
    int e0, t0;
    wr(A_CTRL, {20'h0, acq, core_clock_halver, 7'h0});
    e0 = n_eos;
    wr(A_CMD, 32'h0000_0003);
    wait_ev(1'h1, e0 + 1);
    chk("soc width", 32'((acq + 1) * (core_clock_halver + 1)), 32'(soc_w));
    chk("single index", 32'h0, {28'h0, last_idx});
    t0 = n_tick;
    cyc(8);
    chk("tick count", core_clock_halver ? 32'h4 : 32'h8, 32'(n_tick - t0));
    $display("test soc acq %0d halver %0d done", acq, core_clock_halver);
  endtask

  task automatic t_stst();
    int r0, e0;
    wr(A_CTRL, 32'h0000_0000);
    r0 = n_res;
    e0 = n_eos;
    wr(A_CMD, 32'h0000_0023);
    wait_ev(1'h1, e0 + 1);
    cyc(20);
    chk("stop results", 32'h3, 32'(n_res - r0));
    rdchk("stop position", A_STAT, 32'h0000_03FF, 32'h0000_0003);
    @(posedge clk);
    start_pin <= 1'h1;
    cyc(4);
    start_pin <= 1'h0;
    wait_ev(1'h0, r0 + 4);
    chk("resume index", 32'h3, {28'h0, last_idx});
    wr(A_CMD, 32'h0000_0022);
    cyc(4);
    rdchk("seq reset", A_STAT, 32'h0000_03FF, 32'h0000_0000);
    r0 = n_res;
    wr(A_CMD, 32'h0000_0021);
    wait_ev(1'h0, r0 + 1);
    chk("first after reset", 32'h0, {28'h0, last_idx});
    cyc(60);
    $display("test start-stop done");
  endtask

  task automatic t_cont();
    int r0, e0;
    wr(A_CTRL, 32'h0000_0F40);
    r0 = n_res;
    e0 = n_eos;
    wr(A_CMD, 32'h0000_0013);
    wait_ev(1'h1, e0 + 2);
    chk("cont results", 32'h4, 32'(n_res - r0));
    chk("cont index", 32'h1, {28'h0, last_idx});
    wr(A_CTRL, 32'h0000_0F00);
    rdchk("cont held", A_STAT, 32'h0000_0200, 32'h0000_0200);
    wait_ev(1'h1, e0 + 3);
    cyc(60);
    chk("cont stopped", 32'h6, 32'(n_res - r0));
    rdchk("cont applied", A_STAT, 32'h0000_0200, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0060);
    r0 = n_res;
    wr(A_CMD, 32'h0000_0013);
    wait_ev(1'h0, r0 + 4);
    chk("wrap index", 32'h3, {28'h0, last_idx});
    wr(A_CTRL, 32'h0000_4000);
    cyc(4);
    rdchk("soft reset status", A_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    r0 = n_res;
    cyc(40);
    chk("soft reset quiet", 32'h0, 32'(n_res - r0));
    $display("test continuous done");
  endtask

  task automatic t_susp(logic [1:0] m);
    int r0, e0;
    wr(A_CTRL, {18'h0, m, 12'hF00});
    r0 = n_res;
    e0 = n_eos;
    wr(A_CMD, 32'h0000_0013);
    @(negedge clk);
    while (soc !== 1'h1) @(negedge clk);
    @(posedge clk);
    emu_susp <= 1'h1;
    cyc(100);
    chk("suspended results", (m < 2) ? 32'h2 : 32'(3 - m), 32'(n_res - r0));
    chk("halted", {31'h0, m != 2'h0}, {31'h0, halted});
    emu_susp <= 1'h0;
    cyc(100);
    chk("resumed results", 32'h2, 32'(n_res - r0));
    chk("resumed eos", 32'h1, 32'(n_eos - e0));
    chk("resumed index", 32'h1, {28'h0, last_idx});
    chk("released", 32'h0, {31'h0, halted});
    $display("test suspend mode %0d done", m);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    for (int i = 0; i < 6; i++) begin
      t_soc(acq_tab[i / 2], 1'(i % 2));
    end
    t_stst();
    t_cont();
    for (int m = 0; m < 4; m++) begin
      t_susp(2'(m));
    end
    summarize();
  end
endmodule

`default_nettype wire
